// >>> ibic_core.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "ibic_defines.svh"
// Notes on behaviour
// - Master ack mode adds one clock after the word
// - Master ack clock: release if tx, low if rx
// - No ack clock when ack mode off
// - Slave acks own address or general call
// - Addressed slave: release if tx, low if rx
// - Slave without ack mode counts no ack
// - Bit count field sets word length
// - Start forces bit count to zero
// - Rate select sets master SCL speed
// - High phase timing waits for SCL line
// - Address mode matches own seven-bit address
// - Free format: first word is data
// - Master select cleared by stop or noise
// - Slave transmit select follows direction bit
// - Master transmit select inverts acked direction
// - Transmit select cleared by stop or noise
// - Start command when bus free sends address
// - Stop command when bus busy
// - Stop waits for SCL release
// - Busy flag follows start and stop
// - Status layout, reset leaves service pending
// - Service pending clears on word, holds SCL
// - Master transmitter noise check on SCL rise
module ibic_core (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire ibic_pkg::ibic_avs_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output ibic_pkg::ibic_pad_t pad_o
);
  import ibic_pkg::*;

  // ==========================================================
  // Line synchronisers and condition detection
  logic [1:0] scl_sync_q, sda_sync_q;
  logic scl_prev_q, sda_prev_q;
  logic scl_line, sda_line, scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  assign scl_line = scl_sync_q[1];
  assign sda_line = sda_sync_q[1];
  assign scl_rise = scl_line & ~scl_prev_q;
  assign scl_fall = ~scl_line & scl_prev_q;
  assign start_det = scl_line & scl_prev_q & sda_prev_q & ~sda_line;
  assign stop_det = scl_line & scl_prev_q & ~sda_prev_q & sda_line;

  // ==========================================================
  // Bus slave: one wait cycle, answer on the second edge
  logic acc_q;
  logic [31:0] rdata_q;
  logic [13:0] idx;
  logic req, wr_fire, rd_fire, wr_c1, wr_oa, wr_c2, dbuf_acc;
  logic [7:0] wd;

  assign req = avs_req_i.read | avs_req_i.write;
  assign idx = avs_req_i.address[15:2];
  assign wd = avs_req_i.writedata[7:0];
  assign avs_waitrequest_o = req & ~acc_q;
  assign avs_readdata_o = rdata_q;
  assign wr_fire = avs_req_i.write & acc_q & avs_req_i.byteenable[0];
  assign rd_fire = avs_req_i.read & acc_q;
  assign wr_c1 = wr_fire & (idx == `IBIC_IDX_CTRL1);
  assign wr_oa = wr_fire & (idx == `IBIC_IDX_OWNADR);
  assign wr_c2 = wr_fire & (idx == `IBIC_IDX_CTRL2);
  assign dbuf_acc = (wr_fire | rd_fire) & (idx == `IBIC_IDX_DATA);

  // ==========================================================
  // Software-visible state
  logic [2:0] bc_q, sck_q;
  logic ackm_q, free_q, mst_q, trx_q, busy_q, pin_q, noise_q, hit_q, gc_q, lrb_q;
  logic [6:0] own_q;
  logic [1:0] mode_q;
  logic [7:0] shreg_q, status;
  logic en, cmd_start, cmd_stop;

  assign en = (mode_q == `IBIC_MODE_BUS);
  assign cmd_start = wr_c2 & (wd[7:4] == `IBIC_CMD_START) & ~busy_q & en;
  assign cmd_stop = wr_c2 & (wd[7:4] == `IBIC_CMD_STOP) & busy_q & en;
  assign status = {mst_q, trx_q, busy_q, pin_q, noise_q, hit_q, gc_q, lrb_q};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      acc_q <= req & ~acc_q;
      if (avs_req_i.read & ~acc_q) begin
        unique case (idx)
          `IBIC_IDX_CTRL1: rdata_q <= {24'h000000, bc_q, ackm_q, 1'b0, sck_q};
          `IBIC_IDX_OWNADR: rdata_q <= {24'h000000, own_q, free_q};
          `IBIC_IDX_CTRL2: rdata_q <= {24'h000000, mst_q, trx_q, busy_q, pin_q, mode_q, 2'h0};
          `IBIC_IDX_STATUS: rdata_q <= {24'h000000, status};
          `IBIC_IDX_DATA: rdata_q <= {24'h000000, shreg_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sck_q <= 3'h0;
      ackm_q <= 1'b0;
      own_q <= 7'h00;
      free_q <= 1'b0;
      mode_q <= `IBIC_MODE_RST;
    end else begin
      if (wr_c1) begin
        sck_q <= wd[`IBIC_C1_SCK_HI:`IBIC_C1_SCK_LO];
        ackm_q <= wd[`IBIC_C1_ACK];
      end
      if (wr_oa) begin
        own_q <= wd[7:1];
        free_q <= wd[0];
      end
      // Mode is only switched while lines idle; nothing here checks it
      if (wr_c2) begin
        mode_q <= wd[`IBIC_C2_MODE_HI:`IBIC_C2_MODE_LO];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bc_q <= 3'h0;
    end else if (wr_c1) begin
      bc_q <= wd[`IBIC_C1_BC_HI:`IBIC_C1_BC_LO];
    end else if (start_det) begin
      bc_q <= 3'h0;
    end
  end

  // ==========================================================
  // Bit engine, shared by master and slave, timed by line edges
  logic [3:0] cnt_q, nbits, total;
  logic first_q, part_q, addr_ok_q, rxbit_q, gen_q;
  logic data_ph, ack_ph, word_done, addr_eval, match_w, ok_w, involve, noise_evt;
  logic arm_q, fall_ok;
  logic [7:0] byte_w;
  logic sda_oe_q, scl_oe_q;
  ibic_mstate_t ms_q;

  assign nbits = (bc_q == 3'h0) ? 4'h8 : {1'b0, bc_q};
  assign total = nbits + {3'h0, ackm_q};
  assign data_ph = cnt_q < nbits;
  assign ack_ph = ackm_q & (cnt_q == nbits);
  // The fall that closes a start has no rise before it: not a bit clock
  assign fall_ok = scl_fall & arm_q;
  assign word_done = en & busy_q & part_q & fall_ok & (cnt_q == total - 4'h1);
  assign byte_w = {shreg_q[6:0], rxbit_q};
  assign addr_eval = en & part_q & fall_ok & first_q & (cnt_q == 4'h7) & ~gen_q & ~free_q;
  assign match_w = (byte_w[7:1] == own_q) | (byte_w == 8'h00);
  assign ok_w = (cnt_q == 4'h7) ? match_w : addr_ok_q;
  assign involve = gen_q | hit_q | (first_q & (free_q | ok_w)) | free_q;
  assign noise_evt = en & gen_q & trx_q & scl_rise & data_ph & (sda_line == sda_oe_q);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      arm_q <= 1'b0;
    end else if (start_det) begin
      arm_q <= 1'b0;
    end else if (scl_rise) begin
      arm_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      first_q <= 1'b0;
      part_q <= 1'b0;
      addr_ok_q <= 1'b0;
      rxbit_q <= 1'b1;
      shreg_q <= 8'h00;
    end else begin
      if (start_det) begin
        cnt_q <= 4'h0;
        first_q <= 1'b1;
        part_q <= en;
        addr_ok_q <= 1'b0;
      end else if (stop_det) begin
        part_q <= 1'b0;
      end else if (en & busy_q & part_q & fall_ok) begin
        if (word_done) begin
          cnt_q <= 4'h0;
          first_q <= 1'b0;
          part_q <= involve;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
        if (data_ph) begin
          shreg_q <= byte_w;
        end
        if (addr_eval) begin
          addr_ok_q <= match_w;
        end
      end
      if (en & part_q & scl_rise) begin
        rxbit_q <= sda_line;
      end
      if (dbuf_acc & avs_req_i.write) begin
        shreg_q <= wd;
      end
    end
  end

  // ==========================================================
  // Status flags; a hardware set or clear wins over a software write, but a CTRL2 write wins over hardware for mst_q and trx_q
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      pin_q <= 1'b1;
      noise_q <= 1'b0;
      hit_q <= 1'b0;
      gc_q <= 1'b0;
      lrb_q <= 1'b0;
    end else begin
      if (start_det) begin
        busy_q <= 1'b1;
      end else if (stop_det) begin
        busy_q <= 1'b0;
      end
      if (word_done & involve) begin
        pin_q <= 1'b0;
      end else if (dbuf_acc | (wr_c2 & wd[`IBIC_C2_PIN])) begin
        pin_q <= 1'b1;
      end
      if (noise_evt) begin
        noise_q <= 1'b1;
      end else if (dbuf_acc | wr_c2) begin
        noise_q <= 1'b0;
      end
      if ((addr_eval & match_w) | (word_done & first_q & free_q & ~gen_q)) begin
        hit_q <= 1'b1;
      end else if (dbuf_acc | stop_det) begin
        hit_q <= 1'b0;
      end
      if (addr_eval & (byte_w == 8'h00)) begin
        gc_q <= 1'b1;
      end else if (start_det | stop_det) begin
        gc_q <= 1'b0;
      end
      if (en & part_q & scl_rise) begin
        lrb_q <= sda_line;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mst_q <= 1'b0;
      trx_q <= 1'b0;
    end else begin
      if (wr_c2) begin
        mst_q <= wd[`IBIC_C2_MST];
        trx_q <= wd[`IBIC_C2_TRX];
      end else if (noise_evt | stop_det) begin
        mst_q <= 1'b0;
        trx_q <= 1'b0;
      end else if (addr_eval & match_w & (byte_w != 8'h00)) begin
        trx_q <= byte_w[0];
      end else if (en & gen_q & first_q & ack_ph & scl_rise & ~sda_line & ~free_q) begin
        trx_q <= ~shreg_q[0];
      end
    end
  end

  // ==========================================================
  // Master clock generator
  logic [10:0] tmr_q, half;
  logic stop_req_q, tmr_hit;

  assign half = `IBIC_HALF_BASE << sck_q;
  assign tmr_hit = (tmr_q >= half - 11'h001);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ms_q <= M_IDLE;
      tmr_q <= 11'h000;
      gen_q <= 1'b0;
      stop_req_q <= 1'b0;
    end else begin
      tmr_q <= tmr_q + 11'h001;
      if (cmd_stop) begin
        stop_req_q <= 1'b1;
      end
      if (word_done & noise_q) begin
        gen_q <= 1'b0;
      end
      unique case (ms_q)
        M_IDLE: begin
          tmr_q <= 11'h000;
          if (cmd_start) begin
            ms_q <= M_START;
            gen_q <= 1'b1;
          end
        end
        M_START: begin
          if (tmr_hit) begin
            ms_q <= M_LOW;
            tmr_q <= 11'h000;
          end
        end
        M_LOW: begin
          if (tmr_hit & stop_req_q) begin
            ms_q <= M_STOPL;
            tmr_q <= 11'h000;
            stop_req_q <= 1'b0;
          end else if (tmr_hit & ~gen_q) begin
            ms_q <= M_IDLE;
          end else if (tmr_hit & pin_q) begin
            ms_q <= M_HIGH;
            tmr_q <= 11'h000;
          end
        end
        M_HIGH: begin
          if (~scl_line) begin
            tmr_q <= 11'h000;
          end else if (tmr_hit) begin
            ms_q <= M_LOW;
            tmr_q <= 11'h000;
          end
        end
        M_STOPL: begin
          if (tmr_hit) begin
            ms_q <= M_STOPH;
            tmr_q <= 11'h000;
          end
        end
        M_STOPH: begin
          if (~scl_line) begin
            tmr_q <= 11'h000;
          end else if (tmr_hit) begin
            ms_q <= M_STOPE;
            tmr_q <= 11'h000;
          end
        end
        M_STOPE: begin
          if (tmr_hit) begin
            ms_q <= M_IDLE;
            gen_q <= 1'b0;
          end
        end
        default: begin
          ms_q <= M_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Pin drivers; data and ack bits change SDA only while SCL is low, M_START and M_STOPH drive it with SCL high, M_STOPL with SCL low
  logic sda_oe_d, scl_oe_d, stretch;

  assign stretch = en & busy_q & part_q & ~pin_q & (gen_q | hit_q | free_q);

  always_comb begin
    sda_oe_d = sda_oe_q;
    if (!en) begin
      sda_oe_d = 1'b0;
    end else if (ms_q == M_START || ms_q == M_STOPL || ms_q == M_STOPH) begin
      sda_oe_d = 1'b1;
    end else if (ms_q == M_STOPE) begin
      sda_oe_d = 1'b0;
    end else if (!scl_line) begin
      sda_oe_d = 1'b0;
      if (busy_q & part_q & data_ph) begin
        sda_oe_d = trx_q & (gen_q | hit_q | free_q) & ~shreg_q[7];
      end else if (busy_q & part_q & ack_ph & first_q) begin
        sda_oe_d = ~gen_q & (addr_ok_q | free_q);
      end else if (busy_q & part_q & ack_ph) begin
        sda_oe_d = ~trx_q & (gen_q | hit_q | free_q);
      end
    end
  end

  always_comb begin
    scl_oe_d = stretch;
    if (en & (ms_q == M_LOW || ms_q == M_STOPL)) begin
      scl_oe_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
    end
  end

  assign pad_o = '{scl_o: 1'b0, scl_oe: scl_oe_q, sda_o: 1'b0, sda_oe: sda_oe_q};

  // ==========================================================
  // Checks
  property p_stretch_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    stretch |=> pad_o.scl_oe;
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) else $error("SCL not held");

  property p_start_bc;
    @(posedge clk_sys_i) disable iff (rst_i)
    (start_det && !wr_c1) |=> (bc_q == 3'h0);
  endproperty
  a_start_bc: assert property (p_start_bc) else $error("bit count kept on start");

  property p_busy_set;
    @(posedge clk_sys_i) disable iff (rst_i)
    start_det |=> busy_q;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set");

  property p_busy_clr;
    @(posedge clk_sys_i) disable iff (rst_i)
    (stop_det && !start_det) |=> !busy_q;
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared");

  property p_noise;
    @(posedge clk_sys_i) disable iff (rst_i)
    (noise_evt && !wr_c2) |=> (noise_q && !mst_q && !trx_q);
  endproperty
  a_noise: assert property (p_noise) else $error("noise not handled");

  property p_mst_stop;
    @(posedge clk_sys_i) disable iff (rst_i)
    (stop_det && !wr_c2) |=> !mst_q;
  endproperty
  a_mst_stop: assert property (p_mst_stop) else $error("master kept after stop");

  property p_pin_set;
    @(posedge clk_sys_i) disable iff (rst_i)
    (dbuf_acc && !word_done) |=> pin_q;
  endproperty
  a_pin_set: assert property (p_pin_set) else $error("pending not set");

  property p_high_wait;
    @(posedge clk_sys_i) disable iff (rst_i)
    (ms_q == M_HIGH && !scl_line) |=> (tmr_q == 11'h000);
  endproperty
  a_high_wait: assert property (p_high_wait) else $error("high counted while low");

  property p_stop_wait;
    @(posedge clk_sys_i) disable iff (rst_i)
    (ms_q == M_STOPH && !scl_line) |=> (ms_q == M_STOPH);
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("stop before release");

  property p_ack_cnt;
    @(posedge clk_sys_i) disable iff (rst_i)
    (word_done && !ackm_q) |-> (cnt_q == nbits - 4'h1);
  endproperty
  a_ack_cnt: assert property (p_ack_cnt) else $error("ack clock counted");
endmodule

// >>> ibic_defines.svh
`ifndef IBIC_DEFINES_SVH
`define IBIC_DEFINES_SVH
// ==========================================================
// Register indices, byte address = index * 4
`define IBIC_IDX_CTRL1 14'h2020
`define IBIC_IDX_OWNADR 14'h2021
`define IBIC_IDX_CTRL2 14'h2022
`define IBIC_IDX_STATUS 14'h2023
`define IBIC_IDX_DATA 14'h2024
// ==========================================================
// Field positions
`define IBIC_C1_BC_HI 7
`define IBIC_C1_BC_LO 5
`define IBIC_C1_ACK 4
`define IBIC_C1_SCK_HI 2
`define IBIC_C1_SCK_LO 0
`define IBIC_C2_MST 7
`define IBIC_C2_TRX 6
`define IBIC_C2_BB 5
`define IBIC_C2_PIN 4
`define IBIC_C2_MODE_HI 3
`define IBIC_C2_MODE_LO 2
// ==========================================================
// Reset values and codes
`define IBIC_STATUS_RST 8'h10
`define IBIC_CTRL1_RST 8'h00
`define IBIC_OWNADR_RST 8'h00
`define IBIC_MODE_RST 2'h0
`define IBIC_MODE_BUS 2'h2
`define IBIC_CMD_START 4'hF
`define IBIC_CMD_STOP 4'hD
// ==========================================================
// Timing: half SCL period = base << rate select
`define IBIC_HALF_BASE 11'h008
`endif

// >>> ibic_pkg.sv
package ibic_pkg;
  typedef struct packed {
    logic [15:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ibic_avs_req_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } ibic_pad_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_LOW = 3'h3,
    M_HIGH = 3'h2,
    M_STOPL = 3'h6,
    M_STOPH = 3'h7,
    M_STOPE = 3'h5
  } ibic_mstate_t;
endpackage

// >>> ibic_bus_model.sv
`timescale 1ns/100ps
// ==========================================================
// Two-wire slave peer: acks its address, takes or sends bytes
module ibic_bus_model (
  // Bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  // Settings
  input wire logic [6:0] addr_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic stretch_i,
  // Line pull-downs and observations
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic [7:0] rx_byte_o,
  output logic mack_o,
  output int rises_o
);
  logic [7:0] sh;
  int bitn;
  logic first, hit, rd;
  initial begin
    scl_oe_o = 0;
    sda_oe_o = 0;
    rx_byte_o = 0;
    mack_o = 1;
    rises_o = 0;
    sh = 0;
    bitn = 0;
    first = 0;
    hit = 0;
    rd = 0;
  end
  // Start restarts framing, stop drops the selection
  always @(negedge sda_i) if (scl_i) begin
    bitn = 0;
    first = 1;
    hit = 0;
    rises_o = 0;
  end
  always @(posedge sda_i) if (scl_i) hit = 0;
  always @(posedge scl_i) begin
    rises_o++;
    if (bitn < 8) begin
      sh = {sh[6:0], sda_i};
      bitn++;
      if (bitn == 8) rx_byte_o = sh;
    end else begin
      mack_o = sda_i;
      bitn = 0;
      first = 0;
    end
  end
  // Data changes only while SCL is low
  always @(negedge scl_i) begin
    #50;
    sda_oe_o = 0;
    if (bitn == 8 && first) begin
      hit = (sh[7:1] == addr_i);
      rd = sh[0];
      sda_oe_o = hit;
    end else if (bitn == 8) begin
      sda_oe_o = hit && !rd;
    end else if (hit && rd && !first) begin
      sda_oe_o = !tx_byte_i[7 - bitn];
    end
    // Stretch far above four machine cycles
    if (stretch_i) begin
      scl_oe_o = 1;
      #1000;
      scl_oe_o = 0;
    end
  end
endmodule

// >>> ibic_core_tb.sv
`timescale 1ns/100ps
`include "ibic_defines.svh"
module ibic_core_tb;
  import ibic_pkg::*;
  // ==========================================================
  // Clock, bus lines and peer
  logic clk, rst, jam_scl, jam_sda, stretch, wait_req, m_scl_oe, m_sda_oe, m_ack;
  ibic_avs_req_t req;
  ibic_pad_t pad;
  logic [31:0] rdata;
  logic [7:0] m_rx, q;
  int m_rises, bad_count, check_count, r0;
  realtime t_rise, per;
  wire scl_line;
  wire sda_line;
  // Open-drain lines with pull-ups
  assign scl_line = ~(pad.scl_oe | m_scl_oe | jam_scl);
  assign sda_line = ~(pad.sda_oe | m_sda_oe | jam_sda);
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge scl_line) begin
    per = $realtime - t_rise;
    t_rise = $realtime;
  end
  ibic_core u_dut (.clk_sys_i(clk), .rst_i(rst), .avs_req_i(req), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .scl_i(scl_line), .sda_i(sda_line), .pad_o(pad));
  ibic_bus_model u_peer (.scl_i(scl_line), .sda_i(sda_line), .addr_i(7'h50),
    .tx_byte_i(8'h96), .stretch_i(stretch), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe),
    .rx_byte_o(m_rx), .mack_o(m_ack), .rises_o(m_rises));
  // ==========================================================
  // Bus access and checks
  task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] wd,
      output logic [7:0] rv);
    @(posedge clk);
    req <= '{address: {idx, 2'b00}, read: !w, write: w, writedata: {24'h0, wd},
      byteenable: 4'hF};
    do @(posedge clk); while (wait_req !== 1'b0);
    rv = rdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rdc(input logic [13:0] idx, input logic [7:0] mask, input logic [7:0] exp,
      input string m);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    cmp(x & mask, exp, m);
  endtask
  // Poll a status bit; polling bounds the wait
  task automatic wait_stat(input int b, input logic v);
    int n;
    logic [7:0] s;
    n = 0;
    do begin
      bus(1'b0, `IBIC_IDX_STATUS, 8'h00, s);
      n++;
    end while (s[b] !== v && n < 3000);
    if (n >= 3000) begin
      bad_count++;
      $display("BAD %0t status bit %0d stuck", $time, b);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
  // ==========================================================
  // Tests
  initial begin
    req = '0;
    rst = 1;
    jam_scl = 0;
    jam_sda = 0;
    stretch = 0;
    bad_count = 0;
    check_count = 0;
    t_rise = 0;
    per = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(`IBIC_IDX_STATUS, 8'hFF, 8'h10, "status reset");
    rdc(`IBIC_IDX_CTRL1, 8'hFF, 8'h00, "ctrl1 reset");
    wr(`IBIC_IDX_STATUS, 8'hFF);
    rdc(`IBIC_IDX_STATUS, 8'hFF, 8'h10, "status read only");
    rdc(14'h0100, 8'hFF, 8'h00, "unmapped read");
    // Address word with a preset bit count, peer stretching
    wr(`IBIC_IDX_CTRL1, 8'h90);
    wr(`IBIC_IDX_OWNADR, 8'h20);
    wr(`IBIC_IDX_CTRL2, 8'h08);
    wr(`IBIC_IDX_DATA, 8'hA0);
    stretch <= 1'b1;
    wr(`IBIC_IDX_CTRL2, 8'hF8);
    // Start reaches the flag only after the line synchronisers
    repeat (10) @(posedge clk);
    rdc(`IBIC_IDX_STATUS, 8'h20, 8'h20, "busy after start");
    wait_stat(4, 1'b0);
    cmp(m_rx, 8'hA0, "address word");
    cmp(m_rises[7:0], 8'd9, "address clocks");
    rdc(`IBIC_IDX_STATUS, 8'hF9, 8'hE0, "master tx acked");
    rdc(`IBIC_IDX_CTRL1, 8'hE0, 8'h00, "count cleared by start");
    r0 = m_rises;
    wr(`IBIC_IDX_CTRL1, 8'h90);
    wr(`IBIC_IDX_DATA, 8'hB5);
    wait_stat(4, 1'b0);
    cmp(8'(m_rises - r0), 8'd5, "short word clocks");
    stretch <= 1'b0;
    wr(`IBIC_IDX_CTRL2, 8'hD8);
    wait_stat(5, 1'b0);
    rdc(`IBIC_IDX_STATUS, 8'hE0, 8'h00, "after stop");
    // Master read at rate one
    wr(`IBIC_IDX_CTRL1, 8'h11);
    wr(`IBIC_IDX_DATA, 8'hA1);
    wr(`IBIC_IDX_CTRL2, 8'hF8);
    wait_stat(4, 1'b0);
    cmp({7'h0, per >= 800.0 && per <= 950.0}, 8'h01, "rate one period");
    rdc(`IBIC_IDX_STATUS, 8'hC1, 8'h80, "master rx after ack");
    bus(1'b0, `IBIC_IDX_DATA, 8'h00, q);
    wait_stat(4, 1'b0);
    cmp({7'h0, m_ack}, 8'h00, "master ack low");
    rdc(`IBIC_IDX_DATA, 8'hFF, 8'h96, "read word");
    wait_stat(4, 1'b0);
    wr(`IBIC_IDX_CTRL2, 8'hD8);
    wait_stat(5, 1'b0);
    // Unanswered address, no ack clock, stop against held SCL
    wr(`IBIC_IDX_CTRL1, 8'h10);
    wr(`IBIC_IDX_DATA, 8'hA4);
    wr(`IBIC_IDX_CTRL2, 8'hF8);
    wait_stat(4, 1'b0);
    rdc(`IBIC_IDX_STATUS, 8'hC1, 8'hC1, "nack keeps tx");
    r0 = m_rises;
    wr(`IBIC_IDX_CTRL1, 8'h00);
    wr(`IBIC_IDX_DATA, 8'h5A);
    wait_stat(4, 1'b0);
    cmp(8'(m_rises - r0), 8'd8, "no ack clock");
    jam_scl <= 1'b1;
    wr(`IBIC_IDX_CTRL2, 8'hD8);
    repeat (100) @(posedge clk);
    rdc(`IBIC_IDX_STATUS, 8'h20, 8'h20, "stop held off");
    jam_scl <= 1'b0;
    wait_stat(5, 1'b0);
    // Line forced low while the address goes out
    wr(`IBIC_IDX_CTRL1, 8'h10);
    wr(`IBIC_IDX_DATA, 8'hFF);
    wr(`IBIC_IDX_CTRL2, 8'hF8);
    @(negedge scl_line);
    @(posedge clk);
    jam_sda <= 1'b1;
    wait_stat(3, 1'b1);
    rdc(`IBIC_IDX_STATUS, 8'hC8, 8'h08, "noise drops master");
    jam_sda <= 1'b0;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(`IBIC_IDX_STATUS, 8'hFF, 8'h10, "status after second reset");
    report_and_stop();
  end
endmodule
